/* File: logic/wsk_device.sv */
// Overview of operation
// - Service word is trigger or disable key
// - Host toggles all bits each trigger
// - First trigger 5555h enters window mode
// - Then triggers alternate 2AAAh, 5555h, ...
// - Key: two back-to-back transfers, long window
// - First key word is 2F6Bh
// - Second key word 1097h, immediately after
// - Wrong key order raises watchdog fault
// - Off flag set when disabled, else clear
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module wsk_device #(
  parameter int TRIG_CNT_W = 8
) (
  input wire logic mclk,
  input wire logic srst,
  wsk_link_if.dev link,
  input wire logic wd_restart,
  output logic wd_window,
  output logic wd_off,
  output logic wd_fault,
  output logic [1:0] fault_cause,
  output logic trig_ok,
  output logic parity_err,
  output logic [TRIG_CNT_W-1:0] trig_count
);

  wsk_pkg::wsk_dev_state_e state_r;
  wsk_pkg::wsk_dev_state_e state_nxt;
  logic [wsk_pkg::VAL_W-1:0] exp_r;
  logic [wsk_pkg::VAL_W-1:0] exp_nxt;
  logic armed_r;
  logic armed_nxt;
  logic fault_r;
  logic fault_nxt;
  logic [1:0] cause_r;
  logic [1:0] cause_nxt;
  logic trig_r;
  logic trig_nxt;
  logic perr_r;
  logic window_r;
  logic off_r;
  logic [TRIG_CNT_W-1:0] tcnt_r;
  logic rd_valid_r;
  logic [wsk_pkg::WORD_W-1:0] rd_word_r;

  logic to_service;
  logic par_ok;
  logic svc;
  logic [wsk_pkg::VAL_W-1:0] val;
  logic is_t1;
  logic is_k1;
  logic is_k2;
  logic [wsk_pkg::VAL_W-1:0] rd_val;

  // Frame decode
  always_comb begin
    to_service = link.xfer_valid && link.xfer_write && (link.xfer_addr == wsk_pkg::SERVICE_ADDR);
    par_ok = wsk_pkg::frame_ok(link.xfer_data);
    svc = to_service && par_ok;
    val = link.xfer_data[wsk_pkg::WORD_W-1:wsk_pkg::VAL_LSB];
    is_t1 = (val == wsk_pkg::TRIG_FIRST);
    is_k1 = (val == wsk_pkg::KEY_FIRST);
    is_k2 = (val == wsk_pkg::KEY_SECOND);
  end

  // Service word interpretation
  always_comb begin
    state_nxt = state_r;
    exp_nxt = exp_r;
    armed_nxt = armed_r;
    fault_nxt = 1'b0;
    cause_nxt = cause_r;
    trig_nxt = 1'b0;
    if (wd_restart) begin
      state_nxt = wsk_pkg::DEV_LONG;
      exp_nxt = wsk_pkg::TRIG_FIRST;
      armed_nxt = 1'b0;
      cause_nxt = wsk_pkg::CAUSE_NONE;
    end else if (armed_r && link.xfer_valid) begin
      armed_nxt = 1'b0;
      if (svc && is_k2) begin
        state_nxt = wsk_pkg::DEV_OFF;
      end else begin
        fault_nxt = 1'b1;
        cause_nxt = wsk_pkg::CAUSE_KEY;
      end
    end else if (svc) begin
      case (state_r)
        wsk_pkg::DEV_LONG: begin
          if (is_t1) begin
            state_nxt = wsk_pkg::DEV_WIN;
            exp_nxt = wsk_pkg::TRIG_SECOND;
            trig_nxt = 1'b1;
          end else if (is_k1) begin
            armed_nxt = 1'b1;
          end else if (is_k2) begin
            fault_nxt = 1'b1;
            cause_nxt = wsk_pkg::CAUSE_KEY;
          end
        end
        wsk_pkg::DEV_WIN: begin
          if (val == exp_r) begin
            exp_nxt = ~exp_r;
            trig_nxt = 1'b1;
          end else begin
            fault_nxt = 1'b1;
            cause_nxt = wsk_pkg::CAUSE_TRIGGER;
          end
        end
        wsk_pkg::DEV_OFF: begin
          state_nxt = wsk_pkg::DEV_OFF;
        end
        default: begin
          state_nxt = wsk_pkg::DEV_LONG;
        end
      endcase
    end
  end

  // State and trigger sequence
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= wsk_pkg::DEV_LONG;
      exp_r <= wsk_pkg::TRIG_FIRST;
    end else begin
      state_r <= state_nxt;
      exp_r <= exp_nxt;
    end
  end

  // Disable key arming
  always_ff @(posedge mclk) begin
    if (srst) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // Fault and trigger reporting
  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_r <= 1'b0;
      cause_r <= wsk_pkg::CAUSE_NONE;
      trig_r <= 1'b0;
      perr_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      cause_r <= cause_nxt;
      trig_r <= trig_nxt;
      perr_r <= to_service && !par_ok;
    end
  end

  // Valid trigger counter
  always_ff @(posedge mclk) begin
    if (srst) begin
      tcnt_r <= '0;
    end else if (wd_restart) begin
      tcnt_r <= '0;
    end else if (trig_nxt) begin
      tcnt_r <= tcnt_r + 1'b1;
    end
  end

  // Mode levels
  always_ff @(posedge mclk) begin
    if (srst) begin
      window_r <= 1'b0;
      off_r <= 1'b0;
    end else begin
      window_r <= (state_nxt == wsk_pkg::DEV_WIN);
      off_r <= (state_nxt == wsk_pkg::DEV_OFF);
    end
  end

  // Read-back of the service register
  always_comb begin
    rd_val = wsk_pkg::VAL_ZERO;
    rd_val[wsk_pkg::OFF_FLAG_BIT-wsk_pkg::VAL_LSB] = off_r;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_valid_r <= 1'b0;
      rd_word_r <= '0;
    end else begin
      rd_valid_r <= link.xfer_valid && !link.xfer_write;
      if (link.xfer_valid && !link.xfer_write) begin
        if (link.xfer_addr == wsk_pkg::SERVICE_ADDR) begin
          rd_word_r <= wsk_pkg::make_frame(rd_val);
        end else begin
          rd_word_r <= wsk_pkg::make_frame(wsk_pkg::VAL_ZERO);
        end
      end
    end
  end

  assign link.rd_valid = rd_valid_r;
  assign link.rd_word = rd_word_r;
  assign link.wd_fault = fault_r;
  assign wd_window = window_r;
  assign wd_off = off_r;
  assign wd_fault = fault_r;
  assign fault_cause = cause_r;
  assign trig_ok = trig_r;
  assign parity_err = perr_r;
  assign trig_count = tcnt_r;

endmodule

`default_nettype wire

/* File: logic/wsk_host.sv */
`timescale 1ns/1ps
`default_nettype none

module wsk_host (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [wsk_pkg::AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  wsk_link_if.host link
);

  wsk_pkg::wsk_hst_state_e state_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic [wsk_pkg::EVT_W-1:0] sts_r;
  logic [wsk_pkg::EVT_W-1:0] sts_nxt;
  logic [wsk_pkg::EVT_W-1:0] mask_r;
  logic [wsk_pkg::WORD_W-1:0] raw_r;
  logic [wsk_pkg::WORD_W-1:0] last_rd_r;
  logic [wsk_pkg::VAL_W-1:0] exp_r;
  logic off_lvl_r;
  logic done_r;
  logic xv_r;
  logic xw_r;
  logic [wsk_pkg::WORD_W-1:0] xd_r;

  logic req;
  logic take;
  logic wr_take;
  logic cmd;
  logic [wsk_pkg::EVT_W-1:0] ev;
  logic [31:0] rd_mux;
  logic [wsk_pkg::VAL_W-1:0] trig_val;

  always_comb begin
    req = avs_read || avs_write;
    take = req && !wait_r;
    wr_take = avs_write && take;
    cmd = wr_take && (avs_address == wsk_pkg::REG_CTRL) && (state_r == wsk_pkg::HST_IDLE);
    // Restarted sequence sends the first trigger value
    trig_val = avs_writedata[wsk_pkg::CTRL_RESEQ] ? wsk_pkg::TRIG_FIRST : exp_r;
    ev = '0;
    ev[wsk_pkg::EVT_FAULT] = link.wd_fault;
    ev[wsk_pkg::EVT_OFF] = link.rd_valid && link.rd_word[wsk_pkg::OFF_FLAG_BIT];
    ev[wsk_pkg::EVT_DONE] = done_r;
    sts_nxt = sts_r | ev;
    if (wr_take && avs_address == wsk_pkg::REG_STATUS) begin
      sts_nxt = (sts_r & ~avs_writedata[wsk_pkg::EVT_W-1:0]) | ev;
    end
    rd_mux = '0;
    case (avs_address)
      wsk_pkg::REG_STATUS: begin
        rd_mux[wsk_pkg::EVT_W-1:0] = sts_r;
        rd_mux[wsk_pkg::STS_BUSY] = (state_r != wsk_pkg::HST_IDLE);
        rd_mux[wsk_pkg::STS_OFFLVL] = off_lvl_r;
      end
      wsk_pkg::REG_MASK: rd_mux[wsk_pkg::EVT_W-1:0] = mask_r;
      wsk_pkg::REG_RAW: rd_mux[wsk_pkg::WORD_W-1:0] = raw_r;
      wsk_pkg::REG_RDATA: rd_mux[wsk_pkg::WORD_W-1:0] = last_rd_r;
      default: rd_mux = '0;
    endcase
  end

  // Avalon slave: answer one cycle after request
  always_ff @(posedge mclk) begin
    if (srst) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
    end else begin
      wait_r <= !(req && wait_r);
      if (req && wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Registers written by software
  always_ff @(posedge mclk) begin
    if (srst) begin
      mask_r <= '0;
      raw_r <= '0;
    end else if (wr_take) begin
      if (avs_address == wsk_pkg::REG_MASK) begin
        mask_r <= avs_writedata[wsk_pkg::EVT_W-1:0];
      end
      if (avs_address == wsk_pkg::REG_RAW) begin
        raw_r <= avs_writedata[wsk_pkg::WORD_W-1:0];
      end
    end
  end

  // Sticky status and interrupt
  always_ff @(posedge mclk) begin
    if (srst) begin
      sts_r <= '0;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      irq_r <= |(sts_nxt & mask_r);
    end
  end

  // Trigger sequence tracking
  always_ff @(posedge mclk) begin
    if (srst) begin
      exp_r <= wsk_pkg::TRIG_FIRST;
    end else if (cmd && avs_writedata[wsk_pkg::CTRL_TRIG]) begin
      exp_r <= ~trig_val;
    end else if (cmd && avs_writedata[wsk_pkg::CTRL_RESEQ]) begin
      exp_r <= wsk_pkg::TRIG_FIRST;
    end
  end

  // Read-back capture
  always_ff @(posedge mclk) begin
    if (srst) begin
      last_rd_r <= '0;
      off_lvl_r <= 1'b0;
    end else if (link.rd_valid) begin
      last_rd_r <= link.rd_word;
      off_lvl_r <= link.rd_word[wsk_pkg::OFF_FLAG_BIT];
    end
  end

  // Frame sequencer
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= wsk_pkg::HST_IDLE;
      xv_r <= 1'b0;
      xw_r <= 1'b0;
      xd_r <= '0;
      done_r <= 1'b0;
    end else begin
      xv_r <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        wsk_pkg::HST_IDLE: begin
          if (cmd && avs_writedata[wsk_pkg::CTRL_TRIG]) begin
            xv_r <= 1'b1;
            xw_r <= 1'b1;
            xd_r <= wsk_pkg::make_frame(trig_val);
            done_r <= 1'b1;
          end else if (cmd && avs_writedata[wsk_pkg::CTRL_DIS]) begin
            xv_r <= 1'b1;
            xw_r <= 1'b1;
            xd_r <= wsk_pkg::make_frame(wsk_pkg::KEY_FIRST);
            state_r <= wsk_pkg::HST_KEY2;
          end else if (cmd && avs_writedata[wsk_pkg::CTRL_READ]) begin
            xv_r <= 1'b1;
            xw_r <= 1'b0;
            state_r <= wsk_pkg::HST_WAITRD;
          end else if (cmd && avs_writedata[wsk_pkg::CTRL_RAW]) begin
            xv_r <= 1'b1;
            xw_r <= 1'b1;
            xd_r <= raw_r;
            done_r <= 1'b1;
          end
        end
        wsk_pkg::HST_KEY2: begin
          xv_r <= 1'b1;
          xw_r <= 1'b1;
          xd_r <= wsk_pkg::make_frame(wsk_pkg::KEY_SECOND);
          done_r <= 1'b1;
          state_r <= wsk_pkg::HST_IDLE;
        end
        wsk_pkg::HST_WAITRD: begin
          if (link.rd_valid) begin
            done_r <= 1'b1;
            state_r <= wsk_pkg::HST_IDLE;
          end
        end
        default: state_r <= wsk_pkg::HST_IDLE;
      endcase
    end
  end

  assign link.xfer_valid = xv_r;
  assign link.xfer_write = xw_r;
  assign link.xfer_addr = wsk_pkg::SERVICE_ADDR;
  assign link.xfer_data = xd_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq = irq_r;

endmodule

`default_nettype wire

/* File: logic/wsk_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface wsk_link_if;
  logic xfer_valid;
  logic xfer_write;
  logic [wsk_pkg::ADDR_W-1:0] xfer_addr;
  logic [wsk_pkg::WORD_W-1:0] xfer_data;
  logic rd_valid;
  logic [wsk_pkg::WORD_W-1:0] rd_word;
  logic wd_fault;

  modport dev (
    input xfer_valid,
    input xfer_write,
    input xfer_addr,
    input xfer_data,
    output rd_valid,
    output rd_word,
    output wd_fault
  );

  modport host (
    output xfer_valid,
    output xfer_write,
    output xfer_addr,
    output xfer_data,
    input rd_valid,
    input rd_word,
    input wd_fault
  );
endinterface

`default_nettype wire

/* File: logic/wsk_pkg.sv */
`default_nettype none

package wsk_pkg;

  // Link word layout
  localparam int WORD_W = 16;
  localparam int VAL_W = 15;
  localparam int ADDR_W = 7;
  localparam int VAL_LSB = 1;
  localparam int PAR_BIT = 0;
  localparam logic [ADDR_W-1:0] SERVICE_ADDR = 7'h0a;

  // Service values
  localparam logic [VAL_W-1:0] TRIG_FIRST = 15'h5555;
  localparam logic [VAL_W-1:0] TRIG_SECOND = 15'h2aaa;
  localparam logic [VAL_W-1:0] KEY_FIRST = 15'h2f6b;
  localparam logic [VAL_W-1:0] KEY_SECOND = 15'h1097;
  localparam logic [VAL_W-1:0] VAL_ZERO = 15'h0000;

  // Read-back word: off flag at frame bit 4
  localparam int OFF_FLAG_BIT = 4;

  // Fault causes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_TRIGGER = 2'h1;
  localparam logic [1:0] CAUSE_KEY = 2'h2;

  typedef enum logic [2:0] {
    DEV_LONG = 3'b001,
    DEV_WIN = 3'b010,
    DEV_OFF = 3'b100
  } wsk_dev_state_e;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b001,
    HST_KEY2 = 3'b010,
    HST_WAITRD = 3'b100
  } wsk_hst_state_e;

  // Host register map (byte addresses)
  localparam int AVS_ADDR_W = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_MASK = 5'h08;
  localparam logic [4:0] REG_RAW = 5'h0c;
  localparam logic [4:0] REG_RDATA = 5'h10;

  // Control bits
  localparam int CTRL_TRIG = 0;
  localparam int CTRL_DIS = 1;
  localparam int CTRL_READ = 2;
  localparam int CTRL_RAW = 3;
  localparam int CTRL_RESEQ = 4;

  // Status bits: events 2:0, levels above
  localparam int EVT_W = 3;
  localparam int EVT_FAULT = 0;
  localparam int EVT_OFF = 1;
  localparam int EVT_DONE = 2;
  localparam int STS_BUSY = 8;
  localparam int STS_OFFLVL = 9;

  // Odd parity over the whole 16-bit frame
  function automatic logic [WORD_W-1:0] make_frame(input logic [VAL_W-1:0] v);
    return {v, ~^v};
  endfunction

  function automatic logic frame_ok(input logic [WORD_W-1:0] f);
    return ^f;
  endfunction

endpackage

`default_nettype wire

/* File: test/watchdog_service_key_check_test.sv */
`timescale 1ns/1ps
`default_nettype none

module watchdog_service_key_check_test;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic wd_restart = 1'b0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, irq, wd_window, wd_off, wd_fault, trig_ok, parity_err;
  logic [1:0] fault_cause;
  logic [7:0] trig_count;
  logic [14:0] v;
  int fail_count = 0, check_count = 0, fault_n = 0, par_n = 0, trig_n = 0, n, i;

  wsk_link_if u_wsk_link_if ();
  wsk_host u_wsk_host (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link(u_wsk_link_if));
  wsk_device #(.TRIG_CNT_W(8)) u_wsk_device (.mclk(mclk), .srst(srst), .link(u_wsk_link_if),
    .wd_restart(wd_restart), .wd_window(wd_window), .wd_off(wd_off), .wd_fault(wd_fault),
    .fault_cause(fault_cause), .trig_ok(trig_ok), .parity_err(parity_err), .trig_count(trig_count));
  wsk_properties u_wsk_properties (.mclk(mclk), .srst(srst), .xfer_valid(u_wsk_link_if.xfer_valid),
    .xfer_write(u_wsk_link_if.xfer_write), .xfer_addr(u_wsk_link_if.xfer_addr),
    .xfer_data(u_wsk_link_if.xfer_data), .rd_valid(u_wsk_link_if.rd_valid),
    .rd_word(u_wsk_link_if.rd_word), .wd_fault(u_wsk_link_if.wd_fault));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (!srst) begin
      fault_n += wd_fault;
      par_n += parity_err;
      trig_n += trig_ok;
    end
  end

  function automatic logic [15:0] fr(input logic [14:0] x);
    return {x, ~^x};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    chk(avs_waitrequest, 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task cmd(input logic [31:0] c);
    int k;
    av(1'b1, wsk_pkg::REG_CTRL, c);
    k = 0;
    do begin
      av(1'b0, wsk_pkg::REG_STATUS, 32'h0);
      k++;
    end while (q[wsk_pkg::EVT_DONE] !== 1'b1 && k < 20);
    chk(q[wsk_pkg::EVT_DONE], 32'h1);
    av(1'b1, wsk_pkg::REG_STATUS, 32'h4);
  endtask

  task raw(input logic [15:0] f);
    av(1'b1, wsk_pkg::REG_RAW, {16'h0, f});
    cmd(32'h8);
  endtask

  task restart;
    @(posedge mclk);
    wd_restart <= 1'b1;
    @(posedge mclk);
    wd_restart <= 1'b0;
    @(posedge mclk);
  endtask

  task conclude;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    conclude();
  end

  initial begin
    void'($urandom(23));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    av(1'b0, wsk_pkg::REG_STATUS, 32'h0);
    chk(q, 32'h0);
    chk({wd_window, wd_off, fault_cause, trig_count}, 32'h0);
    av(1'b1, 5'h14, $urandom);
    av(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    for (i = 0; i < 4; i++) begin
      v = 15'($urandom);
      if (v == wsk_pkg::TRIG_FIRST || v == wsk_pkg::KEY_FIRST || v == wsk_pkg::KEY_SECOND) v = 15'h0001;
      raw(fr(v));
    end
    chk({wd_window, trig_count}, 32'h0);
    chk(fault_n, 0);
    n = 2 * $urandom_range(1, 3) + 1;
    for (i = 0; i < n; i++) cmd(32'h1);
    chk({wd_window, trig_count}, {1'b1, n[7:0]});
    chk(trig_n, n);
    chk(fault_n, 0);
    cmd(32'h11);
    chk(fault_n, 1);
    chk(fault_cause, wsk_pkg::CAUSE_TRIGGER);
    chk(irq, 1'b0);
    av(1'b1, wsk_pkg::REG_STATUS, 32'h7);
    av(1'b1, wsk_pkg::REG_MASK, 32'h1);
    restart();
    chk({wd_window, fault_cause, trig_count}, 32'h0);
    raw(fr(wsk_pkg::KEY_SECOND));
    chk(fault_n, 2);
    chk(fault_cause, wsk_pkg::CAUSE_KEY);
    chk(irq, 1'b1);
    av(1'b1, wsk_pkg::REG_STATUS, 32'h1);
    av(1'b0, wsk_pkg::REG_STATUS, 32'h0);
    chk({irq, q[0]}, 32'h0);
    restart();
    raw(fr(wsk_pkg::KEY_FIRST));
    cmd(32'h4);
    chk(fault_n, 3);
    av(1'b0, wsk_pkg::REG_RDATA, 32'h0);
    chk(q[wsk_pkg::OFF_FLAG_BIT], 1'b0);
    raw(fr(wsk_pkg::TRIG_FIRST) ^ 16'h0001);
    chk(par_n, 1);
    chk(wd_window, 1'b0);
    restart();
    cmd(32'h2);
    chk(wd_off, 1'b1);
    chk(fault_n, 3);
    cmd(32'h11);
    chk(trig_count, 8'h00);
    cmd(32'h4);
    av(1'b0, wsk_pkg::REG_RDATA, 32'h0);
    chk(q[wsk_pkg::OFF_FLAG_BIT], 1'b1);
    av(1'b0, wsk_pkg::REG_STATUS, 32'h0);
    chk(q[wsk_pkg::STS_OFFLVL], 1'b1);
    restart();
    chk(wd_off, 1'b0);
    cmd(32'h11);
    chk({wd_window, trig_count}, {1'b1, 8'h01});
    chk(trig_n, n + 1);
    conclude();
  end
endmodule

`default_nettype wire

/* File: test/wsk_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module wsk_properties (
  input wire logic mclk,
  input wire logic srst,
  input wire logic xfer_valid,
  input wire logic xfer_write,
  input wire logic [wsk_pkg::ADDR_W-1:0] xfer_addr,
  input wire logic [wsk_pkg::WORD_W-1:0] xfer_data,
  input wire logic rd_valid,
  input wire logic [wsk_pkg::WORD_W-1:0] rd_word,
  input wire logic wd_fault
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  localparam logic [15:0] KEY1_F = {wsk_pkg::KEY_FIRST, ~^wsk_pkg::KEY_FIRST};
  localparam logic [15:0] KEY2_F = {wsk_pkg::KEY_SECOND, ~^wsk_pkg::KEY_SECOND};

  property p_rd_after_read;
    xfer_valid && !xfer_write |=> rd_valid;
  endproperty
  a_rd_after_read: assert property (p_rd_after_read) else $error("Read got no answer");
  property p_rd_cause;
    rd_valid |-> $past(xfer_valid && !xfer_write);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("Answer without read");
  property p_rd_parity;
    rd_valid |-> ^rd_word;
  endproperty
  a_rd_parity: assert property (p_rd_parity) else $error("Read frame parity bad");
  property p_rd_reserved;
    rd_valid |-> rd_word[15:5] == 11'h000 && rd_word[3:1] == 3'h0;
  endproperty
  a_rd_reserved: assert property (p_rd_reserved) else $error("Reserved read bits set");
  property p_rd_hold;
    !rd_valid |-> $stable(rd_word);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("Read word moved");
  property p_addr;
    xfer_valid |-> xfer_addr == wsk_pkg::SERVICE_ADDR;
  endproperty
  a_addr: assert property (p_addr) else $error("Transfer off service address");
  property p_fault_after_xfer;
    wd_fault |-> $past(xfer_valid);
  endproperty
  a_fault_after_xfer: assert property (p_fault_after_xfer) else $error("Fault without transfer");
  property p_idle_quiet;
    !xfer_valid [*2] |-> !wd_fault && !rd_valid;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Link output while idle");
  property p_write_no_rd;
    xfer_valid && xfer_write |=> !rd_valid;
  endproperty
  a_write_no_rd: assert property (p_write_no_rd) else $error("Answer after write");

  c_read: cover property (rd_valid && rd_word[4]);
  c_fault: cover property (wd_fault);
  c_key: cover property (xfer_valid && xfer_data == KEY1_F ##1 xfer_valid && xfer_data == KEY2_F);
endmodule

`default_nettype wire
